// *** rtl/lfsr_step.sv ***
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
// One compression step: folds a 16-bit word into a 32-bit signature,
// one bit per unrolled stage, MSB of the word first.
module lfsr_step
	import memory_checker_pkg::*;
(
	input  wire logic [memory_checker_pkg::SIG_W-1:0]  sig_in,
	input  wire logic [memory_checker_pkg::SIG_W-1:0]  poly_in,
	input  wire logic [memory_checker_pkg::DATA_W-1:0] data_in,
	output logic      [memory_checker_pkg::SIG_W-1:0]  sig_out
);

	logic [SIG_W-1:0] stage [0:DATA_W];

	assign stage[0] = sig_in;

	// Galois shift per data bit, feedback taps set by the polynomial
	genvar gi;
	generate
		for (gi = 0; gi < DATA_W; gi++) begin : g_bit
			logic fb;
			assign fb = stage[gi][SIG_W-1] ^ data_in[DATA_W-1-gi];
			assign stage[gi+1] = {stage[gi][SIG_W-2:0], 1'b0} ^ (poly_in & {SIG_W{fb}});
		end
	endgenerate

	assign sig_out = stage[DATA_W];

endmodule : lfsr_step

// *** rtl/memory_checker.sv ***
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
module memory_checker
	import memory_checker_pkg::*;
(
	input  wire logic                              mclk_in,
	input  wire logic                              rstn_in,
	input  wire memory_checker_pkg::checker_cfg_s  cfg_in,
	input  wire logic                              start_in,
	input  wire logic                              word_valid_in,
	input  wire logic [memory_checker_pkg::DATA_W-1:0] word_in,
	input  wire logic                              prng_step_in,
	input  wire logic                              irq_clear_in,
	output logic      [memory_checker_pkg::SIG_W-1:0]  live_sig_out,
	output memory_checker_pkg::block_result_s      result_out,
	output logic                                   block_done_out,
	output logic                                   busy_out,
	output logic                                   irq_out
);


	////////////////////////////////////////////////////////////////////////////
	// Control group: phase, word counter and the busy flag
	checker_state_e     state_reg,  state_next;
	logic [COUNT_W-1:0] count_reg,  count_next;
	logic               busy_reg,   busy_next;

	// Signature group: the running shift register
	logic [SIG_W-1:0]   sig_reg,    sig_next;

	// Result group: latched signature, verdict and done pulse
	block_result_s      result_reg, result_next;
	logic               done_reg,   done_next;

	// Interrupt group: sticky request flag
	logic               irq_reg,    irq_next;

	// Events decoded from the current state and the inputs
	logic [SIG_W-1:0]   stepped_sig;
	logic [DATA_W-1:0]  step_word;
	logic               running;
	logic               word_taken;
	logic               free_step;
	logic               empty_block;
	logic               last_word;
	logic               block_end;
	logic [SIG_W-1:0]   final_sig;
	logic               final_bad;

	////////////////////////////////////////////////////////////////////////////
	// Phase decode, shared by the event logic and the busy flag
	function automatic logic is_running(input checker_state_e st);
		return (st == ST_RUN);
	endfunction : is_running

	// Verdict of one finished block, used by the result and the interrupt
	function automatic logic sig_differs(
		input logic [SIG_W-1:0] sig,
		input logic [SIG_W-1:0] exp_sig
	);
		return (sig != exp_sig);
	endfunction : sig_differs

	////////////////////////////////////////////////////////////////////////////
	// Compression datapath; data is forced to zero outside a block so that
	// a free-run step is a pure shift with feedback
	assign running   = is_running(state_reg);
	assign step_word = running ? word_in : {DATA_W{1'b0}};

	lfsr_step u_step (
		.sig_in  (sig_reg),
		.poly_in (cfg_in.poly),
		.data_in (step_word),
		.sig_out (stepped_sig)
	);

	////////////////////////////////////////////////////////////////////////////
	// Events; a start request beats a free-run step in the same cycle
	assign word_taken  = running && word_valid_in;
	assign free_step   = !running && !start_in && prng_step_in;
	assign empty_block = running && (count_reg == COUNT_ZERO);
	assign last_word   = word_taken && (count_reg == COUNT_ONE);
	assign block_end   = empty_block || last_word;

	// A zero-length block ends with the seed untouched
	assign final_sig   = empty_block ? sig_reg : stepped_sig;
	assign final_bad   = sig_differs(final_sig, cfg_in.expected);

	////////////////////////////////////////////////////////////////////////////
	// Control next values; start is only heard outside a block
	always_comb begin
		state_next = state_reg;
		count_next = count_reg;
		case (state_reg)
			ST_IDLE, ST_DONE: begin
				state_next = ST_IDLE;
				if (start_in) begin
					state_next = ST_RUN;
					count_next = cfg_in.block_len;
				end
			end
			ST_RUN: begin
				if (block_end) begin
					state_next = ST_DONE;
					count_next = cfg_in.block_len;
				end else if (word_taken) begin
					count_next = count_reg - COUNT_ONE;
				end
			end
			default: begin
				state_next = ST_IDLE;
				count_next = COUNT_ZERO;
			end
		endcase
		// Busy is registered so that the pin comes from a flip-flop
		busy_next = is_running(state_next);
	end

	// Control registers
	always_ff @(posedge mclk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			state_reg <= ST_IDLE;
			count_reg <= COUNT_ZERO;
			busy_reg  <= 1'b0;
		end else begin
			state_reg <= state_next;
			count_reg <= count_next;
			busy_reg  <= busy_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Signature next value; the last word restarts the register from the seed
	always_comb begin
		sig_next = sig_reg;
		if (!running && start_in) begin
			sig_next = cfg_in.seed;
		end else if (last_word) begin
			sig_next = cfg_in.seed;
		end else if (word_taken && !empty_block) begin
			sig_next = stepped_sig;
		end else if (free_step) begin
			sig_next = stepped_sig;
		end
	end

	// Signature register
	always_ff @(posedge mclk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			sig_reg <= SIG_RESET;
		end else begin
			sig_reg <= sig_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Result next values; the latched result holds until the next block end
	always_comb begin
		result_next = result_reg;
		done_next   = 1'b0;
		if (block_end) begin
			result_next.signature = final_sig;
			result_next.mismatch  = final_bad;
			done_next             = 1'b1;
		end
	end

	// Result registers
	always_ff @(posedge mclk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			result_reg <= '0;
			done_reg   <= 1'b0;
		end else begin
			result_reg <= result_next;
			done_reg   <= done_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Interrupt next value; a new mismatch wins over a clear in the same cycle
	always_comb begin
		irq_next = irq_reg;
		if (irq_clear_in) begin
			irq_next = 1'b0;
		end
		if (block_end && final_bad && cfg_in.irq_enable) begin
			irq_next = 1'b1;
		end
	end

	// Interrupt register
	always_ff @(posedge mclk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			irq_reg <= 1'b0;
		end else begin
			irq_reg <= irq_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Outputs straight from flip-flops
	assign live_sig_out   = sig_reg;
	assign result_out     = result_reg;
	assign block_done_out = done_reg;
	assign busy_out       = busy_reg;
	assign irq_out        = irq_reg;

endmodule : memory_checker

// *** rtl/memory_checker_pkg.sv ***
package memory_checker_pkg;

	// Widths of the datapath
	localparam int SIG_W   = 32;
	localparam int DATA_W  = 16;
	localparam int COUNT_W = 16;

	// Reset values and counter constants
	localparam logic [SIG_W-1:0]   SIG_RESET   = 32'hFFFFFFFF;
	localparam logic [COUNT_W-1:0] COUNT_ZERO  = 16'h0000;
	localparam logic [COUNT_W-1:0] COUNT_ONE   = 16'h0001;

	// Configuration carried from software side
	typedef struct packed {
		logic [SIG_W-1:0]   poly;
		logic [SIG_W-1:0]   seed;
		logic [SIG_W-1:0]   expected;
		logic [COUNT_W-1:0] block_len;
		logic               irq_enable;
	} checker_cfg_s;

	// Per-block result
	typedef struct packed {
		logic [SIG_W-1:0] signature;
		logic             mismatch;
	} block_result_s;

	// Operating phase
	typedef enum logic [1:0] {
		ST_IDLE,
		ST_RUN,
		ST_DONE
	} checker_state_e;

endpackage : memory_checker_pkg

// *** test/memory_checker_bench.sv ***
`timescale 1ns/1ps

module memory_checker_bench;
	import memory_checker_pkg::*;
	logic	mclk_in = 0, rstn_in = 0, start_in = 0, word_valid_in = 0, prng_step_in = 0, irq_clear_in = 0;
	logic [DATA_W-1:0]	word_in = 16'h0000;
	checker_cfg_s	cfg_in = '0;
	logic [SIG_W-1:0]	live_sig_out;
	block_result_s	result_out;
	logic	block_done_out, busy_out, irq_out, exp_irq = 0;
	logic [31:0]	rnd = 32'hF6838873;
	int	errors = 0, comparisons = 0, cycles = 0;
	memory_checker dut_u (.*);
	////////////////////////////////////////////////////////////////////////////////
	// Clock and hang guard
	initial forever #12.5 mclk_in = ~mclk_in;
	always @(posedge mclk_in) if (++cycles == 4000) begin
		errors++;
		print_verdict;
	end
	// Random source and reference step
	function automatic logic [31:0] lfsr(input logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction : lfsr
	function automatic logic [31:0] fold(input logic [31:0] s, p, input logic [15:0] w);
		for (int i = 15; i >= 0; i--) s = {s[30:0], 1'b0} ^ ((s[31] ^ w[i]) ? p : 32'h0);
		return s;
	endfunction : fold
	task automatic cmp(input string n, input logic [31:0] e, a);
		comparisons++;
		if (a !== e) begin
			errors++;
			$display("[ERR] %s expected %h seen %h", n, e, a);
		end
	endtask : cmp
	task automatic print_verdict;
		$display("errors=%0d comparisons=%0d", errors, comparisons);
		if (errors == 0 && comparisons > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask : print_verdict
	// One block with gaps, refused requests, then a generator step
	task automatic run_block(input int n, input logic bad);
		logic [15:0] w[8];
		checker_cfg_s c;
		logic [31:0] s;
		rnd = lfsr(rnd);
		c = {rnd | 32'h1, lfsr(rnd), 32'h0, n[15:0], rnd[3]};
		s = c.seed;
		for (int k = 0; k < n; k++) begin
			rnd = lfsr(rnd);
			w[k] = rnd[15:0];
			s = fold(s, c.poly, w[k]);
		end
		c.expected = s ^ {31'h0, bad};
		exp_irq |= bad & c.irq_enable;
		@(posedge mclk_in);
		cfg_in <= c;
		start_in <= 1;
		word_valid_in <= 1; // Ignored while idle
		word_in <= ~w[0];
		@(posedge mclk_in);
		start_in <= rnd[5]; // Refused while busy
		prng_step_in <= rnd[6];
		for (int k = 0; k < n; k++) begin
			word_valid_in <= 1;
			word_in <= w[k];
			@(posedge mclk_in);
			rnd = lfsr(rnd);
			if (rnd[0] && k < n - 1) begin
				word_valid_in <= 0;
				word_in <= rnd[31:16];
				@(posedge mclk_in);
			end
		end
		if (n == 0) @(posedge mclk_in); // Empty block ends one cycle after start is taken
		word_valid_in <= 0;
		start_in <= 0;
		prng_step_in <= 0;
		#1;
		cmp("done", 1, block_done_out);
		cmp("busy", 0, busy_out);
		cmp("signature", s, result_out.signature);
		cmp("mismatch", bad, result_out.mismatch);
		cmp("irq", exp_irq, irq_out);
		cmp("live_sig", c.seed, live_sig_out);
		@(posedge mclk_in);
		irq_clear_in <= rnd[7];
		prng_step_in <= 1;
		@(posedge mclk_in);
		irq_clear_in <= 0;
		prng_step_in <= 0;
		if (rnd[7]) exp_irq = 0;
		#1;
		cmp("prng", fold(c.seed, c.poly, 16'h0000), live_sig_out);
		cmp("irq_clear", exp_irq, irq_out);
	endtask : run_block
	////////////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		repeat (6) @(posedge mclk_in);
		rstn_in <= 1;
		#1;
		cmp("reset_sig", SIG_RESET, live_sig_out);
		cmp("reset_busy", 0, busy_out);
		for (int t = 0; t < 30; t++) run_block(t % 10 == 5 ? 0 : t < 3 ? 1 : 8 - t % 8, t % 3 == 1);
		print_verdict;
	end
endmodule : memory_checker_bench

// *** test/memory_checker_properties.sv ***
`timescale 1ns/1ps

module memory_checker_properties
	import memory_checker_pkg::*;
(
	input wire logic	mclk_in,
	input wire logic	rstn_in,
	input wire memory_checker_pkg::checker_cfg_s	cfg_in,
	input wire logic	start_in,
	input wire logic	word_valid_in,
	input wire logic [memory_checker_pkg::DATA_W-1:0]	word_in,
	input wire logic	prng_step_in,
	input wire logic	irq_clear_in,
	input wire logic [memory_checker_pkg::SIG_W-1:0]	live_sig_out,
	input wire memory_checker_pkg::block_result_s	result_out,
	input wire logic	block_done_out,
	input wire logic	busy_out,
	input wire logic	irq_out
);
	// One clock domain, reset disables all checks
	default clocking @(posedge mclk_in); endclocking
	default disable iff (!rstn_in);
	seed_load_a:
	assert property (start_in && !busy_out && cfg_in.block_len != 0 |=> busy_out && live_sig_out == cfg_in.seed)
		else $error("seed not loaded");
	sig_compare_a:
	assert property (block_done_out |-> result_out.mismatch == (result_out.signature != cfg_in.expected))
		else $error("bad compare");
	irq_raise_a:
	assert property (block_done_out && result_out.mismatch && cfg_in.irq_enable |-> irq_out) else $error("no irq");
	irq_cause_a:
	assert property ($rose(irq_out) |-> block_done_out && cfg_in.irq_enable) else $error("stray irq");
	irq_clear_a:
	assert property (irq_clear_in && !busy_out |=> !irq_out) else $error("irq kept");
	block_restart_a:
	assert property (block_done_out |-> !busy_out && live_sig_out == cfg_in.seed) else $error("no restart");
	result_hold_a:
	assert property (!block_done_out |-> $stable(result_out)) else $error("result moved");
	idle_hold_a:
	assert property (!busy_out && !start_in && !prng_step_in |=> $stable(live_sig_out)) else $error("sig moved");
	done_pulse_a:
	assert property (block_done_out |=> !block_done_out) else $error("done not a pulse");
endmodule : memory_checker_properties

bind memory_checker memory_checker_properties chk_u (.*);
